// ==== gcr_host_model.sv ====
// host model: issues single-cycle register strobes toward the bank
`default_nettype none
module gcr_host_model
    import gcr_pkg::*;
(
    // clock
    input wire logic ref_clk_i,
    // register strobes and read data
    output logic [6:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic reg_uart_o,
    input wire logic [31:0] reg_rdata_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        reg_addr_o = 7'h00;
        reg_wdata_o = 32'h0000_0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_uart_o = 1'b0;
    end
    // one write pulse; data lines scrambled once released
    task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic u);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= (a == GCR_ADDR_CONF) ? (d & 32'hFFFD_FFFF) : d;
        reg_uart_o <= u;
        reg_wr_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~reg_wdata_o;
    endtask
    // one read pulse; data taken once settled after the answer edge
    task automatic rd(input logic [6:0] a, output logic [31:0] q);
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o <= 1'b0;
        @(negedge ref_clk_i);
        q = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== gcr_pin_drive.sv ====
// diagnostic pin driver: open collector active low or push-pull active high
`default_nettype none
module gcr_pin_drive
    import gcr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // control
    input wire logic active_i,
    input wire logic push_pull_i,
    // pad
    output logic pad_o,
    output logic pad_oe_n_o
);
    // ------------------------------------------------------------
    // pad registers
    // ------------------------------------------------------------
    // push-pull: always driven, level follows active; open collector:
    // pulled low only when active, otherwise released
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pad_o <= 1'b0;
            pad_oe_n_o <= 1'b1;
        end else if (push_pull_i) begin
            pad_o <= active_i;
            pad_oe_n_o <= 1'b0;
        end else begin
            pad_o <= 1'b0;
            pad_oe_n_o <= ~active_i;
        end
    end
endmodule
`default_nettype wire

// ==== gcr_pkg.sv ====
// package: register map, field positions and reset values of the global config/status bank
`default_nettype none
package gcr_pkg;
    // ------------------------------------------------------------
    // register offsets (7-bit register address)
    // ------------------------------------------------------------
    localparam logic [6:0] GCR_ADDR_CONF = 7'h00; // global_configuration
    localparam logic [6:0] GCR_ADDR_STAT = 7'h01; // global_status_flags
    localparam logic [6:0] GCR_ADDR_INTERFACE_WRITE_COUNTER = 7'h02; // interface_write_counter
    localparam logic [6:0] GCR_ADDR_TARGET = 7'h2D; // target_position_reg
    // ------------------------------------------------------------
    // configuration field positions
    // ------------------------------------------------------------
    localparam int GCR_CONF_W = 18;
    localparam int GCR_BIT_A_STALL = 7; // pin_a_stall_en / pin_a_step_out_en
    localparam int GCR_BIT_B_STALL = 8; // pin_b_stall_en / pin_b_dir_out_en
    localparam int GCR_BIT_B_INDEX = 9;
    localparam int GCR_BIT_B_CHOP = 10;
    localparam int GCR_BIT_B_SKIP = 11;
    localparam int GCR_BIT_A_DRIVE = 12;
    localparam int GCR_BIT_B_DRIVE = 13;
    localparam int GCR_BIT_SMALL_HYST = 14;
    localparam int GCR_BIT_STOP_EN = 15;
    localparam int GCR_BIT_DIRECT = 16;
    localparam int GCR_BIT_TEST = 17;
    // ------------------------------------------------------------
    // status field positions and reset values
    // ------------------------------------------------------------
    localparam int GCR_STAT_W = 3;
    localparam int GCR_STAT_RESET = 0;
    localparam int GCR_STAT_DRV_ERR = 1;
    localparam int GCR_STAT_UV = 2;
    localparam logic [17:0] GCR_CONF_RST = 18'h00000;
    localparam logic [2:0] GCR_STAT_RST = 3'h1;
    localparam logic [7:0] GCR_INTERFACE_WRITE_COUNTER_RST = 8'h00;
    // ------------------------------------------------------------
    // target register coil fields
    // ------------------------------------------------------------
    localparam int GCR_COIL_W = 9;
    localparam int GCR_COIL_A_LSB = 0;
    localparam int GCR_COIL_B_LSB = 16;
    localparam logic [3:0] GCR_HOLD_RST = 4'h0;
    // hysteresis shift amounts (1/16 and 1/32)
    localparam logic [2:0] GCR_HYST_SH_WIDE = 3'h4;
    localparam logic [2:0] GCR_HYST_SH_NARROW = 3'h5;
endpackage
`default_nettype wire

// ==== gcr_regs.sv ====
// global configuration, status flags and interface write counter bank
// ------------------------------------------------------------
// Notes on behaviour
// - step source input 1 external, 0 internal
// - external, bit 7: pin A on stall
// - internal: bit 7 chooses interrupt or step
// - external, bit 8: pin B on stall
// - internal: bit 8 chooses compare or dir
// - external, bit 9: pin B at index
// - external, bit 10: pin B chopper on
// - external, bit 11: toggle B on skip
// - bit 12: pin A drive and polarity
// - bit 13: pin B drive and polarity
// - bit 14: hysteresis 1/16 or 1/32
// - bit 15 plus halt input: stop stepping
// - bit 16: coil currents from target register
// - direct currents scaled by hold setting
// - reset flag set after any reset
// - status read clears the flags
// - driver error clears only when gone
// - pump undervoltage flags and disables driver
// - counter counts UART writes, not SPI
// - reading counter leaves it unchanged
// - counter wraps 255 to 0
// ------------------------------------------------------------
`default_nettype none
module gcr_regs
    import gcr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // register access from the serial interface decoder
    input wire logic [6:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_uart_i,
    output logic [31:0] reg_rdata_o,
    // pin inputs from outside
    input wire logic external_step_source_sel_i,
    input wire logic halt_request_input_i,
    // internal status from the motor core
    input wire logic stall_i,
    input wire logic irq_i,
    input wire logic step_i,
    input wire logic dir_i,
    input wire logic pos_compare_i,
    input wire logic ustep_index_i,
    input wire logic chopper_on_2nd_i,
    input wire logic lost_step_i,
    input wire logic drv_fault_i,
    input wire logic pump_undervoltage_i,
    input wire logic [3:0] hold_current_scale_i,
    input wire logic [19:0] step_freq_thresh_i,
    // diagnostic pads
    output logic fault_pin_a_pad_o,
    output logic fault_pin_a_pad_oe_n_o,
    output logic fault_pin_b_pad_o,
    output logic fault_pin_b_pad_oe_n_o,
    // controls toward the motor core
    output logic sequencer_halt_o,
    output logic driver_enable_o,
    output logic direct_mode_o,
    output logic signed [12:0] coil_a_current_o,
    output logic signed [12:0] coil_b_current_o,
    output logic [19:0] hyst_low_thresh_o
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [17:0] global_configuration; // configuration register
    logic [2:0] global_status_flags; // sticky status flags
    logic [7:0] interface_write_counter; // uart write counter
    logic [31:0] target_position_reg; // target / direct coil register
    logic ext_mode; // synchronised step source select
    logic halt_level; // synchronised halt input
    logic pin_a_active; // pin A logical level
    logic pin_b_active; // pin B logical level
    logic skip_toggle; // toggled on each lost step
    logic stat_rd; // read of status register

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // sign-extend a coil field and scale by the hold setting
    function automatic logic signed [12:0] scale_coil(input logic [8:0] raw,
                                                       input logic [3:0] hold);
        logic signed [12:0] ext;
        logic signed [12:0] prod;
        ext = {{4{raw[8]}}, raw};
        prod = 13'((ext * $signed({1'b0, hold})) >>> 4);
        return prod;
    endfunction

    // ------------------------------------------------------------
    // pin input synchronisers
    // ------------------------------------------------------------
    gcr_sync u_sync_mode (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(external_step_source_sel_i),
        .level_o(ext_mode)
    );

    gcr_sync u_sync_halt (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(halt_request_input_i),
        .level_o(halt_level)
    );

    assign stat_rd = reg_rd_i && (reg_addr_i == GCR_ADDR_STAT);

    // ------------------------------------------------------------
    // configuration and target registers
    // ------------------------------------------------------------
    // bit 17 is stored as written; software keeps it at zero
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            global_configuration <= GCR_CONF_RST;
        end else if (reg_wr_i && reg_addr_i == GCR_ADDR_CONF) begin
            global_configuration <= reg_wdata_i[17:0];
        end
    end

    // target register feeds direct coil mode
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            target_position_reg <= 32'h00000000;
        end else if (reg_wr_i && reg_addr_i == GCR_ADDR_TARGET) begin
            target_position_reg <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // reset flag comes up set; events win over a clearing read
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            global_status_flags <= GCR_STAT_RST;
        end else begin
            if (stat_rd) begin
                global_status_flags[GCR_STAT_RESET] <= 1'b0;
            end
            // drv_err: read clears it only with the fault gone
            if (drv_fault_i) begin
                global_status_flags[GCR_STAT_DRV_ERR] <= 1'b1;
            end else if (stat_rd) begin
                global_status_flags[GCR_STAT_DRV_ERR] <= 1'b0;
            end
            // undervoltage while present, else read clears
            if (pump_undervoltage_i) begin
                global_status_flags[GCR_STAT_UV] <= 1'b1;
            end else if (stat_rd) begin
                global_status_flags[GCR_STAT_UV] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interface write counter
    // ------------------------------------------------------------
    // counts every uart write, mapped address or not, wraps naturally at 8 bits
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            interface_write_counter <= GCR_INTERFACE_WRITE_COUNTER_RST;
        end else if (reg_wr_i && reg_uart_i) begin
            interface_write_counter <= interface_write_counter + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                GCR_ADDR_CONF: reg_rdata_o <= {14'h0000, global_configuration};
                GCR_ADDR_STAT: reg_rdata_o <= {29'h00000000, global_status_flags};
                GCR_ADDR_INTERFACE_WRITE_COUNTER: reg_rdata_o <= {24'h000000, interface_write_counter};
                default: reg_rdata_o <= 32'h00000000; // unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------
    // diagnostic pin selection
    // ------------------------------------------------------------
    // toggle source for lost-step indication
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            skip_toggle <= 1'b0;
        end else if (lost_step_i) begin
            skip_toggle <= ~skip_toggle;
        end
    end

    // pin A: stall in external mode, interrupt or step in internal mode
    always_comb begin
        if (ext_mode) begin
            pin_a_active = global_configuration[GCR_BIT_A_STALL] & stall_i;
        end else if (global_configuration[GCR_BIT_A_STALL]) begin
            pin_a_active = step_i;
        end else begin
            pin_a_active = irq_i;
        end
    end

    // pin B: or of enabled sources in external mode, compare or dir internal
    always_comb begin
        if (ext_mode) begin
            pin_b_active = (global_configuration[GCR_BIT_B_STALL] & stall_i)
                | (global_configuration[GCR_BIT_B_INDEX] & ustep_index_i)
                | (global_configuration[GCR_BIT_B_CHOP] & chopper_on_2nd_i)
                | (global_configuration[GCR_BIT_B_SKIP] & skip_toggle);
        end else if (global_configuration[GCR_BIT_B_STALL]) begin
            pin_b_active = dir_i;
        end else begin
            pin_b_active = pos_compare_i;
        end
    end

    gcr_pin_drive u_drive_a (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .active_i(pin_a_active),
        .push_pull_i(global_configuration[GCR_BIT_A_DRIVE]),
        .pad_o(fault_pin_a_pad_o),
        .pad_oe_n_o(fault_pin_a_pad_oe_n_o)
    );

    gcr_pin_drive u_drive_b (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .active_i(pin_b_active),
        .push_pull_i(global_configuration[GCR_BIT_B_DRIVE]),
        .pad_o(fault_pin_b_pad_o),
        .pad_oe_n_o(fault_pin_b_pad_oe_n_o)
    );

    // ------------------------------------------------------------
    // motor core controls
    // ------------------------------------------------------------
    // emergency stop and driver enable
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sequencer_halt_o <= 1'b0;
            driver_enable_o <= 1'b0;
        end else begin
            sequencer_halt_o <= global_configuration[GCR_BIT_STOP_EN] & halt_level;
            // driver follows the pump level directly, no extra delay stage
            driver_enable_o <= ~pump_undervoltage_i;
        end
    end

    // direct coil mode currents, scaled by the hold setting
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            direct_mode_o <= 1'b0;
            coil_a_current_o <= 13'sh0000;
            coil_b_current_o <= 13'sh0000;
        end else begin
            direct_mode_o <= global_configuration[GCR_BIT_DIRECT];
            if (global_configuration[GCR_BIT_DIRECT]) begin
                coil_a_current_o <= scale_coil(
                    target_position_reg[GCR_COIL_A_LSB +: GCR_COIL_W],
                    hold_current_scale_i);
                coil_b_current_o <= scale_coil(
                    target_position_reg[GCR_COIL_B_LSB +: GCR_COIL_W],
                    hold_current_scale_i);
            end else begin
                coil_a_current_o <= 13'sh0000;
                coil_b_current_o <= 13'sh0000;
            end
        end
    end

    // lower comparison threshold: threshold minus 1/16 or 1/32 of it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hyst_low_thresh_o <= 20'h00000;
        end else if (global_configuration[GCR_BIT_SMALL_HYST]) begin
            hyst_low_thresh_o <= step_freq_thresh_i
                - (step_freq_thresh_i >> GCR_HYST_SH_NARROW);
        end else begin
            hyst_low_thresh_o <= step_freq_thresh_i
                - (step_freq_thresh_i >> GCR_HYST_SH_WIDE);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_INTERFACE_WRITE_COUNTER_INC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_uart_i |=> interface_write_counter
            == 8'($past(interface_write_counter) + 8'h01))
        else $error("counter did not step on uart write");

    AST_INTERFACE_WRITE_COUNTER_SPI: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(reg_wr_i && reg_uart_i) |=> $stable(interface_write_counter))
        else $error("counter moved without uart write");

    AST_INTERFACE_WRITE_COUNTER_WRAP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        reg_wr_i && reg_uart_i && interface_write_counter == 8'hFF
            |=> interface_write_counter == 8'h00)
        else $error("counter did not wrap");

    AST_RST_FLAG: assert property (@(posedge ref_clk_i)
        rst_i |=> global_status_flags[GCR_STAT_RESET])
        else $error("reset flag not set after reset");

    AST_STAT_CLR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        stat_rd && !drv_fault_i && !pump_undervoltage_i |=> global_status_flags == 3'h0)
        else $error("status read did not clear flags");

    AST_DRV_HOLD: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        drv_fault_i |=> global_status_flags[GCR_STAT_DRV_ERR])
        else $error("driver error flag cleared with fault present");

    AST_UV_DIS: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        pump_undervoltage_i |=> !driver_enable_o && global_status_flags[GCR_STAT_UV])
        else $error("driver enabled during undervoltage");

    AST_HALT: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        global_configuration[GCR_BIT_STOP_EN] && halt_level |=> sequencer_halt_o)
        else $error("halt not applied");

    AST_PIN_A_PP: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        global_configuration[GCR_BIT_A_DRIVE] |=> !fault_pin_a_pad_oe_n_o
            && fault_pin_a_pad_o == $past(pin_a_active))
        else $error("pin A push-pull level wrong");

    AST_PIN_B_OC: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !global_configuration[GCR_BIT_B_DRIVE] |=> !fault_pin_b_pad_o
            && fault_pin_b_pad_oe_n_o == !$past(pin_b_active))
        else $error("pin B open collector level wrong");

    AST_PIN_B_DIR: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !ext_mode && global_configuration[GCR_BIT_B_STALL]
            && global_configuration[GCR_BIT_B_DRIVE] |=> fault_pin_b_pad_o == $past(dir_i))
        else $error("pin B not showing direction");

    AST_PIN_A_STALL: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ext_mode && global_configuration[GCR_BIT_A_STALL] && stall_i
            && global_configuration[GCR_BIT_A_DRIVE] |=> fault_pin_a_pad_o)
        else $error("pin A missed stall");
endmodule
`default_nettype wire

// ==== gcr_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`default_nettype none
module gcr_sync
    import gcr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // pin and filtered level
    input wire logic pin_i,
    output logic level_o
);
    logic meta; // first stage, read only by stage two
    logic s2;
    logic s3;
    // ------------------------------------------------------------
    // sampling chain
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            meta <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            meta <= pin_i;
            s2 <= meta;
            s3 <= s2;
        end
    end
    // level changes once stages two and three agree
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else if (s2 == s3) begin
            level_o <= s3;
        end
    end
endmodule
`default_nettype wire

// ==== test_global_config_status_regs.sv ====
// testbench: register bank, diagnostic pads, halt, direct mode, hysteresis
`default_nettype none
module test_global_config_status_regs
    import gcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus, bus and observed signals
    // ------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] pv = 12'h000; // mode, halt and core status inputs
    logic [3:0] hold = 4'h8;
    logic [19:0] thr = 20'h01000;
    logic [6:0] addr;
    logic [31:0] wdata, rdata, q;
    logic wr, rd, uart;
    logic pa, pa_oe_n, pb, pb_oe_n, halt, drv_en, direct;
    logic signed [12:0] coil_a, coil_b;
    logic [19:0] hyst;
    int miscompares = 0;
    int comparisons = 0;
    int src[3] = '{2, 7, 8};
    // pad levels with pull-ups when released
    wire lva = pa_oe_n ? 1'b1 : pa;
    wire lvb = pb_oe_n ? 1'b1 : pb;
    always #5 ref_clk_i = ~ref_clk_i;
    gcr_host_model host (.ref_clk_i(ref_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_uart_o(uart), .reg_rdata_i(rdata));
    gcr_regs uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_uart_i(uart),
        .reg_rdata_o(rdata), .external_step_source_sel_i(pv[0]),
        .halt_request_input_i(pv[1]), .stall_i(pv[2]), .irq_i(pv[3]), .step_i(pv[4]),
        .dir_i(pv[5]), .pos_compare_i(pv[6]), .ustep_index_i(pv[7]),
        .chopper_on_2nd_i(pv[8]), .lost_step_i(pv[9]), .drv_fault_i(pv[10]),
        .pump_undervoltage_i(pv[11]), .hold_current_scale_i(hold),
        .step_freq_thresh_i(thr), .fault_pin_a_pad_o(pa), .fault_pin_a_pad_oe_n_o(pa_oe_n),
        .fault_pin_b_pad_o(pb), .fault_pin_b_pad_oe_n_o(pb_oe_n), .sequencer_halt_o(halt),
        .driver_enable_o(drv_en), .direct_mode_o(direct), .coil_a_current_o(coil_a),
        .coil_b_current_o(coil_b), .hyst_low_thresh_o(hyst));
    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // covers the synchroniser delay of the mode pins
    task automatic settle();
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask
    task automatic pin(input int i, input logic v, input logic ea, input logic eb);
        @(posedge ref_clk_i);
        pv[i] <= v;
        settle();
        chk("pad a", {31'h0, ea}, {31'h0, lva});
        chk("pad b", {31'h0, eb}, {31'h0, lvb});
    endtask
    // one-cycle event pulse on a core input, then pad check
    task automatic pulse(input int i, input logic ea, input logic eb);
        @(posedge ref_clk_i);
        pv[i] <= 1'b1;
        pin(i, 1'b0, ea, eb);
    endtask
    task automatic rdc(input string n, input logic [6:0] a, input logic [31:0] e);
        host.rd(a, q);
        chk(n, e, q);
    endtask
    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (50000) @(posedge ref_clk_i);
        miscompares++;
        summarize();
    end
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc("status", GCR_ADDR_STAT, 32'h1);
        rdc("status", GCR_ADDR_STAT, 32'h0);
        rdc("config", GCR_ADDR_CONF, 32'h0);
        chk("driver en", 32'h1, {31'h0, drv_en});
        $display("test reset done");
        host.wr(GCR_ADDR_CONF, 32'h0, 1'b1);
        host.wr(7'h7F, 32'h5, 1'b0);
        rdc("counter", GCR_ADDR_INTERFACE_WRITE_COUNTER, 32'h1);
        rdc("counter", GCR_ADDR_INTERFACE_WRITE_COUNTER, 32'h1);
        rdc("unmapped", 7'h7F, 32'h0);
        for (int k = 0; k < 254; k++) begin
            host.wr(7'h7F, 32'h0, 1'b1);
        end
        rdc("counter", GCR_ADDR_INTERFACE_WRITE_COUNTER, 32'hFF);
        host.wr(7'h7F, 32'h0, 1'b1);
        rdc("counter", GCR_ADDR_INTERFACE_WRITE_COUNTER, 32'h0);
        $display("test counter done");
        pin(0, 1'b1, 1'b1, 1'b1);
        host.wr(GCR_ADDR_CONF, 32'h1080, 1'b0);
        pin(2, 1'b1, 1'b1, 1'b1);
        pin(2, 1'b0, 1'b0, 1'b1);
        host.wr(GCR_ADDR_CONF, 32'h0080, 1'b0);
        pin(2, 1'b1, 1'b0, 1'b1);
        pin(2, 1'b0, 1'b1, 1'b1);
        for (int k = 0; k < 3; k++) begin
            host.wr(GCR_ADDR_CONF, 32'h2000 | (32'h100 << k), 1'b0);
            pin(src[k], 1'b1, 1'b1, 1'b1);
            pin(src[k], 1'b0, 1'b1, 1'b0);
        end
        host.wr(GCR_ADDR_CONF, 32'h2800, 1'b0);
        pin(9, 1'b0, 1'b1, 1'b0);
        pulse(9, 1'b1, 1'b1);
        pulse(9, 1'b1, 1'b0);
        $display("test external pads done");
        host.wr(GCR_ADDR_CONF, 32'h3000, 1'b0);
        pin(0, 1'b0, 1'b0, 1'b0);
        pin(3, 1'b1, 1'b1, 1'b0);
        pin(6, 1'b1, 1'b1, 1'b1);
        host.wr(GCR_ADDR_CONF, 32'h3180, 1'b0);
        pin(4, 1'b1, 1'b1, 1'b0);
        pin(5, 1'b1, 1'b1, 1'b1);
        pin(4, 1'b0, 1'b0, 1'b1);
        $display("test internal pads done");
        host.wr(GCR_ADDR_CONF, 32'h8000, 1'b0);
        pin(1, 1'b1, 1'b0, 1'b0);
        chk("halt", 32'h1, {31'h0, halt});
        host.wr(GCR_ADDR_CONF, 32'h0, 1'b0);
        settle();
        chk("halt", 32'h0, {31'h0, halt});
        chk("hyst", 32'h0F00, {12'h0, hyst});
        host.wr(GCR_ADDR_CONF, 32'h4000, 1'b0);
        settle();
        chk("hyst", 32'h0F80, {12'h0, hyst});
        host.wr(GCR_ADDR_TARGET, 32'h01F0_0010, 1'b0);
        host.wr(GCR_ADDR_CONF, 32'h10000, 1'b0);
        settle();
        chk("direct", 32'h1, {31'h0, direct});
        chk("coil a", 32'h0008, {19'h0, coil_a});
        chk("coil b", 32'h1FF8, {19'h0, coil_b});
        $display("test control outputs done");
        pin(10, 1'b1, 1'b0, 1'b0);
        rdc("status", GCR_ADDR_STAT, 32'h2);
        rdc("status", GCR_ADDR_STAT, 32'h2);
        pin(10, 1'b0, 1'b0, 1'b0);
        rdc("status", GCR_ADDR_STAT, 32'h2);
        rdc("status", GCR_ADDR_STAT, 32'h0);
        pin(11, 1'b1, 1'b0, 1'b0);
        chk("driver en", 32'h0, {31'h0, drv_en});
        rdc("status", GCR_ADDR_STAT, 32'h4);
        pin(11, 1'b0, 1'b0, 1'b0);
        rdc("status", GCR_ADDR_STAT, 32'h4);
        rdc("status", GCR_ADDR_STAT, 32'h0);
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rdc("status", GCR_ADDR_STAT, 32'h1);
        rdc("config", GCR_ADDR_CONF, 32'h0);
        $display("test status done");
        summarize();
    end
endmodule
`default_nettype wire
